// ===== design/qos_sched_pkg.sv
// Shared constants for the Layer 2 priority scheduler
package qos_sched_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODEM_RATE_OFS = 8'h04;
  localparam logic [7:0] QOS_RATE_OFS = 8'h08;
  localparam logic [7:0] PORT_CFG_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] INT_STAT_OFS = 8'h14;
  localparam logic [7:0] INT_MASK_OFS = 8'h18;
  localparam logic [7:0] OCCUPANCY_OFS = 8'h1C;
  localparam logic [7:0] DROP_BASE_OFS = 8'h20;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int PORT_TRUNK_LSB = 8;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [14:0] MODEM_RATE_RST = 15'h03E8;
  localparam logic [11:0] PORT_CFG_RST = 12'h000;
  localparam logic [31:0] SLVERR_DATA = 32'hDEAD_BEEF;
  // Sizes
  localparam int NUM_PORTS = 4;
  localparam int NUM_QUEUES = 4;
  localparam int LEN_W = 11;
  localparam int OCC_W = 18;
  localparam int FIFO_DEPTH = 8;
  localparam logic [OCC_W-1:0] STORE_BYTES = 18'h20000;
  // Rate quantisation, rates in kbit/s
  localparam logic [14:0] FINE_LIMIT_KBPS = 15'h03E8;
  localparam logic [14:0] FINE_STEP_KBPS = 15'h0040;
  localparam logic [14:0] COARSE_STEP_KBPS = 15'h03E8;
  // Credit accounting: kbit/s added per cycle, a byte costs clock_hz * 8 / 1000
  localparam longint CLOCK_HZ = 250000000;
  localparam longint BYTE_COST_L = CLOCK_HZ * 8 / 1000;
  localparam int CRED_W = 40;
  localparam logic [CRED_W-1:0] BYTE_COST = CRED_W'(BYTE_COST_L);
  localparam logic [CRED_W-1:0] CRED_CAP = CRED_W'(BYTE_COST_L * 2048);
  // Classification modes
  typedef enum logic [1:0] {MODE_PORT, MODE_VLAN, MODE_PORT_VLAN, MODE_RSVD} mode_type;
endpackage : qos_sched_pkg

// ===== design/frame_len_queue.sv
// One priority queue: frame length store with full and empty flags
`timescale 1ns/10ps
`default_nettype none
module frame_len_queue (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [qos_sched_pkg::LEN_W-1:0] push_len,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [qos_sched_pkg::LEN_W-1:0] head_len
);
  localparam int PW = $clog2(qos_sched_pkg::FIFO_DEPTH);
  logic [qos_sched_pkg::LEN_W-1:0] mem_q [qos_sched_pkg::FIFO_DEPTH];
  logic [qos_sched_pkg::LEN_W-1:0] mem_d [qos_sched_pkg::FIFO_DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;

  // Pointer status
  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  assign empty = (wr_q == rd_q);
  assign head_len = mem_q[rd_q[PW-1:0]];

  // Next pointers and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push && !full) begin
      mem_d[wr_q[PW-1:0]] = push_len;
      wr_d = wr_q + 1'b1;
    end
    if (pop && !empty) begin
      rd_d = rd_q + 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < qos_sched_pkg::FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
endmodule : frame_len_queue
`default_nettype wire

// ===== design/l2_priority_sched.sv
// Layer 2 priority classifier, shared store, strict scheduler and rate trimmer
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module l2_priority_sched (
  input wire logic ref_clk,
  input wire logic arst_n,
  // Ingress frame descriptors, one per cycle
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_port,
  input wire logic [qos_sched_pkg::LEN_W-1:0] in_len,
  input wire logic in_tagged,
  input wire logic [2:0] in_pcp,
  // Egress descriptors to the modem transmit path
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_queue,
  output logic [qos_sched_pkg::LEN_W-1:0] out_len,
  // Packet processor enable pin
  input wire logic pp_enable,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NQ = qos_sched_pkg::NUM_QUEUES;
  localparam int CW = qos_sched_pkg::CRED_W;

  // Reset release and pin synchroniser
  logic rst_meta_q, rst_n;
  logic pp_meta_q, pp_sync_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pp_meta_q <= 1'b0;
      pp_sync_q <= 1'b0;
    end else begin
      pp_meta_q <= pp_enable;
      pp_sync_q <= pp_meta_q;
    end
  end

  // Software state
  logic [31:0] ctrl_q, ctrl_d;
  logic [14:0] modem_rate_q, modem_rate_d;
  logic [11:0] port_cfg_q, port_cfg_d;
  logic [3:0] int_stat_q, int_stat_d, int_mask_q, int_mask_d;
  logic [31:0] drop_q [qos_sched_pkg::NUM_PORTS];
  logic [31:0] drop_d [qos_sched_pkg::NUM_PORTS];
  logic [qos_sched_pkg::OCC_W-1:0] occ_q, occ_d;

  logic sched_en;
  qos_sched_pkg::mode_type mode;
  assign mode = qos_sched_pkg::mode_type'(ctrl_q[qos_sched_pkg::CTRL_MODE_LSB +: 2]);
  assign sched_en = ctrl_q[qos_sched_pkg::CTRL_EN_BIT] && !pp_sync_q;

  // Scheduling rate quantisation, one bit wider so the top modem rates round up without wrapping
  logic [15:0] qos_rate;
  always_comb begin
    if (modem_rate_q <= qos_sched_pkg::FINE_LIMIT_KBPS) begin
      qos_rate = 16'((modem_rate_q + qos_sched_pkg::FINE_STEP_KBPS - 15'h0001)
                 & ~(qos_sched_pkg::FINE_STEP_KBPS - 15'h0001));
    end else begin
      qos_rate = 16'(((17'(modem_rate_q) + 17'(qos_sched_pkg::COARSE_STEP_KBPS) - 17'h00001)
                 / 17'(qos_sched_pkg::COARSE_STEP_KBPS)) * 17'(qos_sched_pkg::COARSE_STEP_KBPS));
    end
  end

  // Classification of the arriving frame
  logic [1:0] port_prio, in_queue;
  logic port_trunk;
  assign port_prio = port_cfg_q[{in_port, 1'b0} +: 2];
  assign port_trunk = port_cfg_q[qos_sched_pkg::PORT_TRUNK_LSB + int'(in_port)];
  always_comb begin
    in_queue = 2'h0;
    if (!sched_en) begin
      in_queue = 2'h0; // Disabled: single lowest queue, plain order
    end else if (mode == qos_sched_pkg::MODE_VLAN || (mode == qos_sched_pkg::MODE_PORT_VLAN && port_trunk)) begin
      in_queue = in_tagged ? in_pcp[2:1] : 2'h0;
    end else begin
      in_queue = port_prio;
    end
  end

  // Queues and store admission
  logic [NQ-1:0] q_full, q_empty, q_push, q_pop;
  logic [qos_sched_pkg::LEN_W-1:0] q_head [NQ];
  logic fits, accept, drop;
  assign fits = ({1'b0, occ_q} + (qos_sched_pkg::OCC_W+1)'(in_len))
                <= {1'b0, qos_sched_pkg::STORE_BYTES};
  assign accept = in_valid && fits && !q_full[in_queue];
  assign drop = in_valid && !accept;
  assign in_ready = 1'b1;

  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_queue
      assign q_push[g] = accept && (in_queue == 2'(g));
      frame_len_queue u_queue (
        .clk(ref_clk),
        .rst_n(rst_n),
        .push(q_push[g]),
        .push_len(in_len),
        .pop(q_pop[g]),
        .full(q_full[g]),
        .empty(q_empty[g]),
        .head_len(q_head[g])
      );
    end
  endgenerate

  // Strict priority pick, highest queue number first
  logic pick_valid;
  logic [1:0] pick_q;
  always_comb begin
    pick_valid = 1'b0;
    pick_q = 2'h0;
    for (int i = 0; i < NQ; i++) begin
      if (!q_empty[i]) begin
        pick_valid = 1'b1;
        pick_q = 2'(i);
      end
    end
  end

  // Credit buckets: scheduling rate and modem rate
  logic signed [CW-1:0] qos_cred_q, qos_cred_d, tx_cred_q, tx_cred_d;
  logic [CW-1:0] cost;
  logic dispatch, out_free;
  logic out_valid_q, out_valid_d;
  logic [1:0] out_queue_q, out_queue_d;
  logic [qos_sched_pkg::LEN_W-1:0] out_len_q, out_len_d;
  assign out_free = !out_valid_q || out_ready;
  assign dispatch = pick_valid && out_free && !qos_cred_q[CW-1] && !tx_cred_q[CW-1];
  assign cost = CW'(q_head[pick_q]) * qos_sched_pkg::BYTE_COST;
  assign q_pop = dispatch ? (4'h1 << pick_q) : 4'h0;

  always_comb begin
    qos_cred_d = qos_cred_q + CW'(qos_rate);
    tx_cred_d = tx_cred_q + CW'(modem_rate_q);
    if (qos_cred_d > $signed(qos_sched_pkg::CRED_CAP)) begin
      qos_cred_d = qos_sched_pkg::CRED_CAP;
    end
    if (tx_cred_d > $signed(qos_sched_pkg::CRED_CAP)) begin
      tx_cred_d = qos_sched_pkg::CRED_CAP;
    end
    if (dispatch) begin
      qos_cred_d = qos_cred_d - $signed(cost);
      tx_cred_d = tx_cred_d - $signed(cost);
    end
    out_valid_d = out_free ? dispatch : out_valid_q;
    out_queue_d = dispatch ? pick_q : out_queue_q;
    out_len_d = dispatch ? q_head[pick_q] : out_len_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qos_cred_q <= '0;
      tx_cred_q <= '0;
      out_valid_q <= 1'b0;
      out_queue_q <= 2'h0;
      out_len_q <= '0;
    end else begin
      qos_cred_q <= qos_cred_d;
      tx_cred_q <= tx_cred_d;
      out_valid_q <= out_valid_d;
      out_queue_q <= out_queue_d;
      out_len_q <= out_len_d;
    end
  end
  assign out_valid = out_valid_q;
  assign out_queue = out_queue_q;
  assign out_len = out_len_q;

  // AXI4-Lite channel state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_go, wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_go = aw_hold_q && w_hold_q;
  assign wr_hit = (awaddr_q[7:2] <= qos_sched_pkg::DROP_BASE_OFS[7:2] + 6'h03);

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      qos_sched_pkg::CTRL_OFS: rd_val = ctrl_q;
      qos_sched_pkg::MODEM_RATE_OFS: rd_val = {17'h00000, modem_rate_q};
      qos_sched_pkg::QOS_RATE_OFS: rd_val = {16'h0000, qos_rate};
      qos_sched_pkg::PORT_CFG_OFS: rd_val = {20'h00000, port_cfg_q};
      qos_sched_pkg::STATUS_OFS: rd_val = {27'h0000000, ~q_empty, sched_en};
      qos_sched_pkg::INT_STAT_OFS: rd_val = {28'h0000000, int_stat_q};
      qos_sched_pkg::INT_MASK_OFS: rd_val = {28'h0000000, int_mask_q};
      qos_sched_pkg::OCCUPANCY_OFS: rd_val = {14'h0000, occ_q};
      default: begin
        if (s_axi_araddr[7:4] == qos_sched_pkg::DROP_BASE_OFS[7:4]) begin
          rd_val = drop_q[s_axi_araddr[3:2]];
        end else begin
          rd_hit = 1'b0;
          rd_val = qos_sched_pkg::SLVERR_DATA;
        end
      end
    endcase
  end

  // Bus channels, register writes, drop counting and interrupt status
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    modem_rate_d = modem_rate_q;
    port_cfg_d = port_cfg_q;
    int_mask_d = int_mask_q;
    int_stat_d = int_stat_q;
    drop_d = drop_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? 2'h0 : 2'h2;
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          case ({awaddr_q[7:2], 2'b00})
            qos_sched_pkg::CTRL_OFS: ctrl_d[8*b +: 8] = wdata_q[8*b +: 8];
            default: ;
          endcase
        end
      end
      case ({awaddr_q[7:2], 2'b00})
        qos_sched_pkg::MODEM_RATE_OFS: begin
          if (wstrb_q[0]) modem_rate_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) modem_rate_d[14:8] = wdata_q[14:8];
        end
        qos_sched_pkg::PORT_CFG_OFS: begin
          if (wstrb_q[0]) port_cfg_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) port_cfg_d[11:8] = wdata_q[11:8];
        end
        qos_sched_pkg::INT_STAT_OFS: if (wstrb_q[0]) int_stat_d = int_stat_q & ~wdata_q[3:0];
        qos_sched_pkg::INT_MASK_OFS: if (wstrb_q[0]) int_mask_d = wdata_q[3:0];
        default: ;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_val;
      rresp_d = rd_hit ? 2'h0 : 2'h2;
    end
    if (drop) begin
      drop_d[in_port] = drop_q[in_port] + 32'h0000_0001;
      int_stat_d[in_port] = 1'b1; // Set wins over clear
    end
  end

  // Store occupancy follows admitted and dispatched bytes
  always_comb begin
    occ_d = occ_q;
    if (accept) occ_d = occ_d + qos_sched_pkg::OCC_W'(in_len);
    if (dispatch) occ_d = occ_d - qos_sched_pkg::OCC_W'(q_head[pick_q]);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      ctrl_q <= qos_sched_pkg::CTRL_RST;
      modem_rate_q <= qos_sched_pkg::MODEM_RATE_RST;
      port_cfg_q <= qos_sched_pkg::PORT_CFG_RST;
      int_stat_q <= 4'h0;
      int_mask_q <= 4'h0;
      occ_q <= '0;
      for (int p = 0; p < qos_sched_pkg::NUM_PORTS; p++) begin
        drop_q[p] <= 32'h0000_0000;
      end
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      modem_rate_q <= modem_rate_d;
      port_cfg_q <= port_cfg_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      occ_q <= occ_d;
      drop_q <= drop_d;
    end
  end

  // Level interrupt from unmasked drop events
  assign irq = |(int_stat_q & int_mask_q);
endmodule : l2_priority_sched
`default_nettype wire

// ===== sim/l2_priority_sched_assertions.sv
// Port checker for the priority scheduler
`timescale 1ns/10ps
`default_nettype none
module l2_priority_sched_assertions (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [1:0] out_queue,
  input wire logic [qos_sched_pkg::LEN_W-1:0] out_len,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Overload drops frames instead of stalling ingress
  a_ingress_open: assert property (in_ready) else $error("ingress stalled");
  // A stalled descriptor keeps its queue and length
  a_egress_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_queue) && $stable(out_len)) else $error("egress descriptor changed");
  a_len_legal: assert property (out_valid |-> out_len != '0) else $error("empty frame sent");
  // Register answers for every register read and for every write with address and data taken in the same cycle
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during answer");
  a_bvalid_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_rvalid_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule : l2_priority_sched_assertions
bind l2_priority_sched l2_priority_sched_assertions u_chk (.ref_clk, .arst_n, .in_ready, .out_valid,
  .out_ready, .out_queue, .out_len, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== sim/modem_tx_model.sv
// Modem transmit path model that takes egress descriptors
`timescale 1ns/10ps
`default_nettype none
module modem_tx_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic out_valid,
  input wire logic [1:0] out_queue,
  input wire logic [qos_sched_pkg::LEN_W-1:0] out_len,
  input wire logic hold,
  input wire logic slow,
  output logic out_ready,
  output logic got,
  output logic [1:0] got_queue,
  output logic [qos_sched_pkg::LEN_W-1:0] got_len
);
  logic phase_q;
  // Ready drops while held, and every other cycle when slow
  assign out_ready = !hold && (!slow || phase_q);
  // Report each accepted descriptor for one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 1'b0;
      got <= 1'b0;
      got_queue <= 2'h0;
      got_len <= '0;
    end else begin
      phase_q <= !phase_q;
      got <= out_valid && out_ready;
      got_queue <= out_queue;
      got_len <= out_len;
    end
  end
endmodule : modem_tx_model
`default_nettype wire

// ===== sim/test_l2_priority_sched.sv
// Self-checking bench for the priority scheduler
`timescale 1ns/10ps
`default_nettype none
module test_l2_priority_sched;
  typedef struct packed {logic [2:0] ctrl; logic pp; logic [1:0] port; logic tg; logic [2:0] pcp; logic [1:0] q;} row_type;
  logic ref_clk = 1'b0, arst_n = 1'b0, in_valid = 1'b0, in_tagged = 1'b0, pp_enable = 1'b0;
  logic [1:0] in_port = 2'h0;
  logic [2:0] in_pcp = 3'h0;
  logic [qos_sched_pkg::LEN_W-1:0] in_len = 11'h001;
  logic in_ready, out_valid, out_ready, irq, got, hold = 1'b0, slow = 1'b0;
  logic [1:0] out_queue, got_queue, s_axi_bresp, s_axi_rresp;
  logic [qos_sched_pkg::LEN_W-1:0] out_len, got_len;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] r;
  int n_fail = 0, cmp_count = 0;
  logic [14:0] rate_in [4] = '{15'h0040, 15'h00B4, 15'h03E9, 15'h7FFF};
  logic [31:0] rate_exp [4] = '{32'h40, 32'hC0, 32'h7D0, 32'h80E8};
  // Rows: control mode, pp pin, port, tagged, tag priority, expected queue index
  row_type rows [14] = '{'{3'h3, 1'b0, 2'h0, 1'b1, 3'h0, 2'h0}, '{3'h3, 1'b0, 2'h1, 1'b1, 3'h1, 2'h0},
    '{3'h3, 1'b0, 2'h2, 1'b1, 3'h2, 2'h1}, '{3'h3, 1'b0, 2'h3, 1'b1, 3'h3, 2'h1},
    '{3'h3, 1'b0, 2'h0, 1'b1, 3'h4, 2'h2}, '{3'h3, 1'b0, 2'h1, 1'b1, 3'h5, 2'h2},
    '{3'h3, 1'b0, 2'h2, 1'b1, 3'h6, 2'h3}, '{3'h3, 1'b0, 2'h3, 1'b1, 3'h7, 2'h3},
    '{3'h1, 1'b0, 2'h0, 1'b1, 3'h0, 2'h3}, '{3'h1, 1'b0, 2'h3, 1'b1, 3'h7, 2'h0},
    '{3'h5, 1'b0, 2'h3, 1'b1, 3'h5, 2'h2}, '{3'h5, 1'b0, 2'h1, 1'b1, 3'h7, 2'h2},
    '{3'h3, 1'b1, 2'h3, 1'b1, 3'h7, 2'h0}, '{3'h0, 1'b0, 2'h0, 1'b1, 3'h7, 2'h0}};

  always #2 ref_clk = ~ref_clk;

  l2_priority_sched u_dut (.ref_clk, .arst_n, .in_valid, .in_ready, .in_port, .in_len, .in_tagged, .in_pcp,
    .out_valid, .out_ready, .out_queue, .out_len, .pp_enable, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  modem_tx_model u_modem (.ref_clk, .arst_n, .out_valid, .out_queue, .out_len, .hold, .slow, .out_ready,
    .got, .got_queue, .got_len);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Register write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] wd);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_read

  // Back-to-back frames, priority taken in turn from pcps
  task automatic send(input logic [1:0] p, input logic tg, input logic [11:0] pcps, input int n,
    input logic [10:0] len);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_port <= p;
      in_tagged <= tg;
      in_pcp <= pcps[3*(i%4)+:3];
      in_len <= len;
      @(posedge ref_clk);
    end
    in_valid <= 1'b0;
  endtask : send

  task automatic take(input logic [1:0] q, input logic [10:0] len);
    int t;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (got !== 1'b1 && t < 3000);
    check("egress seen", 32'(got), 32'h1);
    check("egress queue", 32'(got_queue), 32'(q));
    check("egress length", 32'(got_len), 32'(len));
  endtask : take

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axi_read(qos_sched_pkg::CTRL_OFS);
    check("ctrl reset", d, qos_sched_pkg::CTRL_RST);
    axi_read(qos_sched_pkg::MODEM_RATE_OFS);
    check("modem rate reset", d, 32'(qos_sched_pkg::MODEM_RATE_RST));
    axi_read(8'h40);
    check("unmapped resp", 32'(r), 32'h2);
    check("unmapped data", d, qos_sched_pkg::SLVERR_DATA);
    axi_write(8'h40, 32'h0000_0000);
    check("unmapped write resp", 32'(r), 32'h2);
    // Rate rounding, ending at the fastest modem rate
    for (int i = 0; i < 4; i++) begin
      axi_write(qos_sched_pkg::MODEM_RATE_OFS, 32'(rate_in[i]));
      axi_read(qos_sched_pkg::QOS_RATE_OFS);
      check("quantised rate", d, rate_exp[i]);
    end
    axi_write(qos_sched_pkg::PORT_CFG_OFS, 32'h0000_081B);
    check("write resp", 32'(r), 32'h0);
    // Classification table
    foreach (rows[i]) begin
      axi_write(qos_sched_pkg::CTRL_OFS, 32'(rows[i].ctrl));
      pp_enable <= rows[i].pp;
      repeat (600) @(posedge ref_clk);
      send(rows[i].port, rows[i].tg, {4{rows[i].pcp}}, 1, 11'(i + 1));
      take(rows[i].q, 11'(i + 1));
    end
    // Strict order with the modem path stalled, lowest queue loaded first
    axi_write(qos_sched_pkg::CTRL_OFS, 32'h3);
    hold <= 1'b1;
    repeat (600) @(posedge ref_clk);
    send(2'h1, 1'b1, {3'h7, 3'h5, 3'h3, 3'h1}, 4, 11'h008);
    repeat (4) @(posedge ref_clk);
    axi_read(qos_sched_pkg::STATUS_OFS);
    check("queues held", d, 32'h1D);
    hold <= 1'b0;
    slow <= 1'b1;
    take(2'h0, 11'h008);
    for (int i = 3; i > 0; i--) take(2'(i), 11'h008);
    // Overdrive one queue while stalled
    hold <= 1'b1;
    repeat (600) @(posedge ref_clk);
    send(2'h2, 1'b1, 12'h000, 12, 11'h005);
    repeat (4) @(posedge ref_clk);
    axi_read(qos_sched_pkg::DROP_BASE_OFS + 8'h08);
    check("drops port 2", d, 32'h3);
    axi_read(qos_sched_pkg::DROP_BASE_OFS);
    check("drops port 0", d, 32'h0);
    axi_read(qos_sched_pkg::OCCUPANCY_OFS);
    check("occupancy full", d, 32'h28);
    axi_read(qos_sched_pkg::INT_STAT_OFS);
    check("drop event", d, 32'h4);
    check("irq masked", 32'(irq), 32'h0);
    axi_write(qos_sched_pkg::INT_MASK_OFS, 32'h4);
    @(posedge ref_clk);
    check("irq raised", 32'(irq), 32'h1);
    axi_write(qos_sched_pkg::INT_STAT_OFS, 32'h4);
    @(posedge ref_clk);
    check("irq cleared", 32'(irq), 32'h0);
    hold <= 1'b0;
    for (int i = 0; i < 9; i++) take(2'h0, 11'h005);
    axi_read(qos_sched_pkg::OCCUPANCY_OFS);
    check("occupancy empty", d, 32'h0);
    wrap_up();
  end
endmodule : test_l2_priority_sched
`default_nettype wire
